// file: mbw_pkg.sv
// Shared constants, types and address decode for the memory bus wait arbiter.
// Assumes word addresses on a 22-bit space and one 40 MHz system clock.
package mbw_pkg;

  localparam int NSRC = 4;
  localparam int NREG = 8;
  localparam int CFG_W = 4;
  localparam int WAIT_W = 5;
  localparam int EXT_ADDR_W = 20;

  typedef logic [1:0] src_t;
  typedef logic [CFG_W-1:0] cfg_t;
  typedef logic [WAIT_W-1:0] wait_t;

  // Sources, highest priority first
  localparam src_t SRC_WB = 2'h0;
  localparam src_t SRC_RB = 2'h1;
  localparam src_t SRC_PB = 2'h2;
  localparam src_t SRC_DMA = 2'h3;

  typedef enum logic [2:0] {
    RG_SINGLE_ACCESS_RAM_LO,
    RG_SINGLE_ACCESS_RAM_HI,
    RG_EXT,
    RG_OTP,
    RG_FLASH,
    RG_PWD,
    RG_BROM,
    RG_NONE
  } region_e;

  // Wait states beyond the single base cycle
  localparam wait_t W_ZERO = 5'h00;
  localparam wait_t W_ONE = 5'h01;
  localparam wait_t W_PWD = 5'h10;
  localparam int DMA_BASE_CYC = 4;
  localparam wait_t W_DMA_BASE = wait_t'(DMA_BASE_CYC - 1);

  localparam logic [21:0] LO_FIRST = 22'h00_8000;
  localparam logic [21:0] LO_LAST = 22'h00_BFFF;
  localparam logic [21:0] HI_FIRST = 22'h00_C000;
  localparam logic [21:0] HI_LAST = 22'h00_FFFF;
  localparam logic [21:0] EXT_FIRST = 22'h10_0000;
  localparam logic [21:0] EXT_LAST = 22'h2F_FFFF;
  localparam logic [21:0] FLASH_FIRST = 22'h30_0000;
  localparam logic [21:0] PWD_FIRST = 22'h33_FFF8;
  localparam logic [21:0] PWD_LAST = 22'h33_FFFF;
  localparam logic [21:0] OTP_FIRST = 22'h38_0400;
  localparam logic [21:0] OTP_LAST = 22'h38_07FF;
  localparam logic [21:0] BROM_FIRST = 22'h3F_E000;

  function automatic region_e region_of(input logic [31:0] a);
    logic [21:0] w;
    w = a[21:0];
    if (a[31:22] != 10'h000) return RG_NONE;
    if (w >= LO_FIRST && w <= LO_LAST) return RG_SINGLE_ACCESS_RAM_LO;
    if (w >= HI_FIRST && w <= HI_LAST) return RG_SINGLE_ACCESS_RAM_HI;
    if (w >= EXT_FIRST && w <= EXT_LAST) return RG_EXT;
    if (w >= PWD_FIRST && w <= PWD_LAST) return RG_PWD;
    if (w >= FLASH_FIRST && w < PWD_FIRST) return RG_FLASH;
    if (w >= OTP_FIRST && w <= OTP_LAST) return RG_OTP;
    if (w >= BROM_FIRST) return RG_BROM;
    return RG_NONE;
  endfunction

  function automatic logic [NSRC-1:0] src_bit(input src_t s);
    logic [NSRC-1:0] b;
    b = '0;
    b[s] = 1'b1;
    return b;
  endfunction

  function automatic src_t first_src(input logic [NSRC-1:0] c);
    src_t f;
    f = SRC_DMA;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (c[i]) f = src_t'(i);
    end
    return f;
  endfunction

endpackage

// file: wait_if.sv
// Carrier between a region's arbitration logic and its wait-state counter.
// Assumes the owner of the instance drives the ctl side.
`timescale 1ns/10ps
`default_nettype none
interface wait_if;
  import mbw_pkg::*;
  logic start;
  wait_t load;
  logic hold;
  logic busy;
  logic fin;
  modport ctl (output start, output load, output hold, input busy, input fin);
  modport cnt (input start, input load, input hold, output busy, output fin);
endinterface
`default_nettype wire

// file: wait_counter.sv
// Wait-state counter for one memory region.
// Assumes start is only raised while the counter is idle or finishing.
`timescale 1ns/10ps
`default_nettype none
module wait_counter (
  input wire logic i_clk,
  input wire logic i_nrst,
  wait_if.cnt w
);
  import mbw_pkg::*;

  wait_t cnt_q;
  logic busy_q;

  // Hold stretches only the last wait, as a ready line would
  assign w.busy = busy_q;
  assign w.fin = busy_q && (cnt_q == W_ZERO) && !w.hold;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= 1'b0;
      cnt_q <= W_ZERO;
    end else if (w.start && w.load != W_ZERO) begin
      busy_q <= 1'b1;
      cnt_q <= w.load - W_ONE;
    end else if (w.fin) begin
      busy_q <= 1'b0;
    end else if (busy_q && cnt_q != W_ZERO) begin
      cnt_q <= cnt_q - W_ONE;
    end
  end

endmodule
`default_nettype wire

// file: memory_bus_wait_arbiter.sv
// Memory bus wait-state and priority arbiter between CPU buses, DMA and regions.
// Assumes each requester holds request, address and data until its done pulse.
//
// How it works
// - Low RAM blocks answer CPU in zero waits; DMA gets an error.
// - High RAM: CPU data zero waits, program space one, DMA zero waits.
// - External port waits come from timing inputs, stretched by ready.
// - External waveforms always carry at least one wait.
// - External writes finish at once only with write buffer enabled and room.
// - CPU and DMA hitting external port together cost one extra cycle.
// - OTP uses a programmed CPU wait of at least one; no DMA.
// - Flash paged and random waits at least one, random not below paged; no DMA.
// - Password locations always take sixteen waits; no DMA.
// - Boot ROM takes exactly one wait; no DMA.
// - Every DMA word but a buffered external write costs four base cycles plus region waits.
// - Program bus has a 22-bit address and 32-bit data.
// - Data read and write buses have 32-bit address and data.
// - Fetch, read and write proceed together when regions differ.
// - Per region: writes beat data reads, which beat program reads and fetches.
// - Data and program writes share one bus, so never coincide.
// - Program reads and fetches share one bus, so never coincide.
`timescale 1ns/10ps
`default_nettype none
module memory_bus_wait_arbiter #(
  parameter int PADDR_W = 22,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_wb_req,
  input wire logic i_wb_prog,
  input wire logic [ADDR_W-1:0] i_wb_addr,
  input wire logic i_rb_req,
  input wire logic [ADDR_W-1:0] i_rb_addr,
  input wire logic i_pb_req,
  input wire logic [PADDR_W-1:0] i_pb_addr,
  input wire logic i_dma_req,
  input wire logic i_dma_we,
  input wire logic [ADDR_W-1:0] i_dma_addr,
  input wire mbw_pkg::cfg_t i_ext_wait,
  input wire logic i_ext_ready_en,
  input wire logic i_ext_ready,
  input wire logic i_wbuf_en,
  input wire logic i_wbuf_room,
  input wire mbw_pkg::cfg_t i_otp_wait,
  input wire mbw_pkg::cfg_t i_flash_page_wait,
  input wire mbw_pkg::cfg_t i_flash_rand_wait,
  input wire logic i_flash_paged,
  input wire logic [mbw_pkg::NREG-1:0][DATA_W-1:0] i_region_rdata,
  output logic o_wb_done,
  output logic o_rb_done,
  output logic o_pb_done,
  output logic o_dma_done,
  output logic o_dma_err,
  output logic [DATA_W-1:0] o_rb_rdata,
  output logic [DATA_W-1:0] o_pb_rdata,
  output logic [DATA_W-1:0] o_dma_rdata,
  output logic o_wr_stb,
  output mbw_pkg::region_e o_wr_region,
  output logic o_dma_wr_stb,
  output mbw_pkg::region_e o_dma_wr_region,
  output logic o_ext_cs,
  output logic o_ext_rd,
  output logic o_ext_wr,
  output logic [mbw_pkg::EXT_ADDR_W-1:0] o_ext_addr
);
  import mbw_pkg::*;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // ********************************
  // Sources
  // ********************************

  logic [NSRC-1:0] req, we, prog, pending, deny;
  logic [NSRC-1:0] grant, done_d, done_q, busy_d, busy_q;
  logic [ADDR_W-1:0] addr [NSRC];
  region_e rg [NSRC];
  logic [DATA_W-1:0] rdata_q [NSRC];
  logic err_q;

  // One write bus and one program bus keep the pairs apart
  assign req = {i_dma_req, i_pb_req, i_rb_req, i_wb_req};
  assign we = {i_dma_we, 2'b00, 1'b1};
  assign prog = {1'b0, 1'b1, 1'b0, i_wb_prog};
  assign addr[SRC_WB] = i_wb_addr;
  assign addr[SRC_RB] = i_rb_addr;
  assign addr[SRC_PB] = {{(ADDR_W - PADDR_W){1'b0}}, i_pb_addr};
  assign addr[SRC_DMA] = i_dma_addr;

  genvar s;
  generate
    for (s = 0; s < NSRC; s++) begin : g_src
      assign rg[s] = region_of(addr[s]);
      // Masked during its own done cycle so a held request is not served twice
      assign pending[s] = req[s] && !busy_q[s] && !done_q[s];
      if (s == SRC_DMA) begin : g_dma
        assign deny[s] = !(rg[s] == RG_SINGLE_ACCESS_RAM_HI || rg[s] == RG_EXT);
      end else begin : g_cpu
        assign deny[s] = 1'b0;
      end
    end
  endgenerate

  // ********************************
  // Wait tables
  // ********************************

  wait_t ext_w, otp_w, page_w, rand_w;
  wait_t base_w [NREG];

  function automatic wait_t at_least(input cfg_t v, input wait_t m);
    wait_t x;
    x = {1'b0, v};
    return (x < m) ? m : x;
  endfunction

  assign ext_w = at_least(i_ext_wait, W_ONE);
  assign otp_w = at_least(i_otp_wait, W_ONE);
  assign page_w = at_least(i_flash_page_wait, W_ONE);
  // Random is forced up to paged rather than trusting software
  assign rand_w = at_least(i_flash_rand_wait, page_w);

  assign base_w[RG_SINGLE_ACCESS_RAM_LO] = W_ZERO;
  assign base_w[RG_SINGLE_ACCESS_RAM_HI] = W_ZERO;
  assign base_w[RG_EXT] = ext_w;
  assign base_w[RG_OTP] = otp_w;
  assign base_w[RG_FLASH] = i_flash_paged ? page_w : rand_w;
  assign base_w[RG_PWD] = W_PWD;
  assign base_w[RG_BROM] = W_ONE;
  assign base_w[RG_NONE] = W_ZERO;

  // ********************************
  // Regions
  // ********************************

  logic [NREG-1:0] start, fin, post, rbusy, hold_arb;
  src_t win [NREG];
  wait_t load [NREG];
  logic [NSRC-1:0] done_r [NREG];
  logic [NSRC-1:0] grant_r [NREG];
  logic pen_q;

  genvar r;
  generate
    for (r = 0; r < NREG; r++) begin : g_reg
      wait_if wi ();
      logic [NSRC-1:0] cand;
      src_t owner_q;
      logic posted_q;

      for (s = 0; s < NSRC; s++) begin : g_cand
        assign cand[s] = pending[s] && !deny[s] && (rg[s] == region_e'(r));
      end

      assign win[r] = first_src(cand);
      // Conflict penalty is taken only while the port could otherwise start
      assign hold_arb[r] = (r == int'(RG_EXT)) && cand[SRC_DMA]
        && (|cand[SRC_PB:SRC_WB]) && !pen_q && (!rbusy[r] || fin[r]);
      // Each region runs alone, so buses aimed elsewhere go in parallel
      assign start[r] = (|cand) && (!rbusy[r] || fin[r]) && !hold_arb[r];
      assign load[r] = base_w[r]
        + (((r == int'(RG_SINGLE_ACCESS_RAM_HI)) && prog[win[r]]) ? W_ONE : W_ZERO)
        + ((win[r] == SRC_DMA) ? W_DMA_BASE : W_ZERO);
      // A buffered write still runs its full waveform on the port
      assign post[r] = (r == int'(RG_EXT)) && we[win[r]] && i_wbuf_en && i_wbuf_room;
      assign grant_r[r] = start[r] ? src_bit(win[r]) : '0;
      assign done_r[r] = ((fin[r] && !posted_q) ? src_bit(owner_q) : '0)
        | ((start[r] && (load[r] == W_ZERO || post[r])) ? src_bit(win[r]) : '0);

      assign wi.start = start[r];
      assign wi.load = load[r];
      assign wi.hold = (r == int'(RG_EXT)) && i_ext_ready_en && !i_ext_ready;
      assign fin[r] = wi.fin;
      assign rbusy[r] = wi.busy;

      wait_counter u_cnt (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .w(wi.cnt)
      );

      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          owner_q <= SRC_WB;
          posted_q <= 1'b0;
        end else if (start[r]) begin
          owner_q <= win[r];
          posted_q <= post[r];
        end
      end

      prio_write_a:
      assert property (start[r] && cand[SRC_WB] |-> win[r] == SRC_WB)
        else $error("write lost to a lower source");
      prio_read_a:
      assert property (start[r] && cand[SRC_RB] && !cand[SRC_WB] |-> win[r] == SRC_RB)
        else $error("data read lost to program bus or dma");

      if (r == int'(RG_SINGLE_ACCESS_RAM_LO)) begin : g_a_lo
        lo_zero_wait_a:
        assert property (start[r] |=> done_q[$past(win[r])])
          else $error("low ram access not done next cycle");
      end
      if (r == int'(RG_SINGLE_ACCESS_RAM_HI)) begin : g_a_hi
        hi_prog_wait_a:
        // The counter may still be finishing the previous access in the start cycle
        assert property (start[r] && win[r] == SRC_PB
          |-> ##1 (fin[r] && !done_q[SRC_PB]) ##1 done_q[SRC_PB])
          else $error("high ram program access not one wait");
        dma_base_a:
        assert property (start[r] && win[r] == SRC_DMA |-> ##3 fin[r] ##1 done_q[SRC_DMA])
          else $error("dma word not four cycles");
      end
      if (r == int'(RG_EXT)) begin : g_a_ext
        ext_min_wait_a:
        assert property (start[r] |=> rbusy[r] && o_ext_cs)
          else $error("external waveform without a wait");
        ext_post_a:
        assert property (start[r] && !post[r] |=> !done_q[$past(win[r])])
          else $error("unbuffered external access finished early");
        ext_arb_a:
        assert property (hold_arb[r] |-> !start[r] ##1 start[r])
          else $error("cpu dma clash not one cycle");
      end
      if (r == int'(RG_OTP)) begin : g_a_otp
        otp_min_a:
        assert property (start[r] |=> rbusy[r] && !done_q[$past(win[r])])
          else $error("otp access without a wait");
      end
      if (r == int'(RG_FLASH)) begin : g_a_flash
        flash_order_a:
        assert property (start[r] |-> load[r] >= page_w && page_w >= W_ONE && rand_w >= page_w)
          else $error("flash wait order broken");
      end
      if (r == int'(RG_PWD)) begin : g_a_pwd
        pwd_wait_a:
        assert property (start[r] |-> ##16 fin[r])
          else $error("password read not sixteen waits");
      end
      if (r == int'(RG_BROM)) begin : g_a_brom
        brom_wait_a:
        assert property (start[r] |-> ##1 fin[r])
          else $error("boot rom read not one wait");
      end
    end
  endgenerate

  // ********************************
  // Completion
  // ********************************

  always_comb begin
    done_d = pending & deny;
    grant = '0;
    for (int i = 0; i < NREG; i++) begin
      done_d = done_d | done_r[i];
      grant = grant | grant_r[i];
    end
  end

  assign busy_d = (busy_q | grant) & ~done_d;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_q <= '0;
      done_q <= '0;
      err_q <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      err_q <= pending[SRC_DMA] && deny[SRC_DMA];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pen_q <= 1'b0;
    end else if (hold_arb[RG_EXT]) begin
      pen_q <= 1'b1;
    end else if (start[RG_EXT]) begin
      pen_q <= 1'b0;
    end
  end

  generate
    for (s = 0; s < NSRC; s++) begin : g_rdata
      always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          rdata_q[s] <= '0;
        end else if (done_d[s] && !we[s]) begin
          rdata_q[s] <= deny[s] ? '0 : i_region_rdata[rg[s]];
        end
      end
    end
  endgenerate

  lo_dma_deny_a:
  assert property (pending[SRC_DMA] && rg[SRC_DMA] == RG_SINGLE_ACCESS_RAM_LO |=> o_dma_err && o_dma_done)
    else $error("dma reached low ram");

  // ********************************
  // Write strobes and external port
  // ********************************

  logic ext_cs_d, ext_we_q, ext_we;

  assign ext_we = start[RG_EXT] ? we[win[RG_EXT]] : ext_we_q;
  // Strobes stay up through every wait, including ready stretch
  assign ext_cs_d = start[RG_EXT] || (rbusy[RG_EXT] && !fin[RG_EXT]);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wr_stb <= 1'b0;
      o_wr_region <= RG_NONE;
      o_dma_wr_stb <= 1'b0;
      o_dma_wr_region <= RG_NONE;
    end else begin
      o_wr_stb <= done_d[SRC_WB];
      o_wr_region <= rg[SRC_WB];
      o_dma_wr_stb <= done_d[SRC_DMA] && we[SRC_DMA] && !deny[SRC_DMA];
      o_dma_wr_region <= rg[SRC_DMA];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ext_we_q <= 1'b0;
      o_ext_cs <= 1'b0;
      o_ext_rd <= 1'b0;
      o_ext_wr <= 1'b0;
      o_ext_addr <= '0;
    end else begin
      ext_we_q <= ext_we;
      o_ext_cs <= ext_cs_d;
      o_ext_rd <= ext_cs_d && !ext_we;
      o_ext_wr <= ext_cs_d && ext_we;
      if (start[RG_EXT]) begin
        o_ext_addr <= addr[win[RG_EXT]][EXT_ADDR_W-1:0];
      end
    end
  end

  assign o_wb_done = done_q[SRC_WB];
  assign o_rb_done = done_q[SRC_RB];
  assign o_pb_done = done_q[SRC_PB];
  assign o_dma_done = done_q[SRC_DMA];
  assign o_dma_err = err_q;
  assign o_rb_rdata = rdata_q[SRC_RB];
  assign o_pb_rdata = rdata_q[SRC_PB];
  assign o_dma_rdata = rdata_q[SRC_DMA];

endmodule
`default_nettype wire

// file: bus_requester_model.sv
// Requester model for the CPU write, read, program buses and the DMA engine.
// Assumes the bench drives addresses and pulses i_go for one cycle per access.
`timescale 1ns/10ps
`default_nettype none
module bus_requester_model (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [3:0] i_go,
  input wire logic [3:0] i_done,
  output logic [3:0] o_req,
  output logic [3:0][7:0] o_lat
);
  // ****************************************************************
  // Request hold and latency count
  // ****************************************************************
  logic [3:0][7:0] cnt_q;

  // Writes of both spaces share bit 0, program reads and fetches share bit 2,
  // so neither pair can ever be presented together.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_req <= 4'h0;
      o_lat <= '0;
      cnt_q <= '0;
    end else begin
      for (int s = 0; s < 4; s++) begin
        if (o_req[s] && i_done[s]) begin
          o_req[s] <= 1'b0;
          // Counts edges from the one that raised the request to the one seeing done
          o_lat[s] <= cnt_q[s] + 8'h01;
        end else if (o_req[s]) begin
          // Held unchanged while stalled, so a loser keeps its place
          cnt_q[s] <= cnt_q[s] + 8'h01;
        end else if (i_go[s]) begin
          o_req[s] <= 1'b1;
          cnt_q[s] <= 8'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: memory_bus_wait_arbiter_bench.sv
// Self-checking bench for the memory bus wait arbiter.
// Assumes one 40 MHz clock; latency seen by the model is waits plus two.
`timescale 1ns/10ps
`default_nettype none
module memory_bus_wait_arbiter_bench;
  import mbw_pkg::*;
  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] go = 4'h0;
  logic [3:0] req;
  logic [3:0] done;
  logic [3:0][7:0] lat;
  logic wb_prog = 1'b0;
  logic dma_we = 1'b0;
  logic [31:0] wb_addr = 32'h0;
  logic [31:0] rb_addr = 32'h0;
  logic [21:0] pb_addr = 22'h0;
  logic [31:0] dma_addr = 32'h0;
  cfg_t ext_wait = 4'h1;
  cfg_t otp_wait = 4'h1;
  cfg_t pg_wait = 4'h1;
  cfg_t rn_wait = 4'h1;
  logic paged = 1'b1;
  logic rdy_en = 1'b0;
  logic rdy = 1'b1;
  logic wbuf_en = 1'b0;
  logic wbuf_room = 1'b0;
  logic [NREG-1:0][31:0] rdata;
  logic [31:0] rb_rdata;
  logic [31:0] dma_rdata;
  logic dma_err;
  logic ext_cs;
  logic [31:0] pb_rdata;
  logic ext_rd, ext_wr, wr_stb, dma_wr_stb;
  logic [EXT_ADDR_W-1:0] ext_addr;
  logic [EXT_ADDR_W-1:0] ext_a_seen = '0;
  region_e wr_region, dma_wr_region;
  region_e wr_rg_seen = RG_NONE;
  region_e dwr_rg_seen = RG_NONE;
  logic err_seen = 1'b0;
  logic [1:0] ext_seen = 2'h0;
  int errors = 0;
  int checks_done = 0;

  always #12.5 clk = ~clk;
  // Distinct data per region exposes a read served from the wrong place
  always_comb for (int r = 0; r < NREG; r++) rdata[r] = 32'hD000_0000 + 32'(r);
  always @(posedge clk) if (done[3]) err_seen <= dma_err;
  always @(posedge clk) if (ext_cs) ext_seen <= {ext_wr, ext_rd};
  always @(posedge clk) if (ext_cs) ext_a_seen <= ext_addr;
  always @(posedge clk) if (wr_stb) wr_rg_seen <= wr_region;
  always @(posedge clk) if (dma_wr_stb) dwr_rg_seen <= dma_wr_region;

  memory_bus_wait_arbiter DUT (
    .i_clk(clk), .i_nrst(nrst),
    .i_wb_req(req[0]), .i_wb_prog(wb_prog), .i_wb_addr(wb_addr),
    .i_rb_req(req[1]), .i_rb_addr(rb_addr), .i_pb_req(req[2]), .i_pb_addr(pb_addr),
    .i_dma_req(req[3]), .i_dma_we(dma_we), .i_dma_addr(dma_addr),
    .i_ext_wait(ext_wait), .i_ext_ready_en(rdy_en), .i_ext_ready(rdy),
    .i_wbuf_en(wbuf_en), .i_wbuf_room(wbuf_room), .i_otp_wait(otp_wait),
    .i_flash_page_wait(pg_wait), .i_flash_rand_wait(rn_wait), .i_flash_paged(paged),
    .i_region_rdata(rdata),
    .o_wb_done(done[0]), .o_rb_done(done[1]), .o_pb_done(done[2]), .o_dma_done(done[3]),
    .o_dma_err(dma_err), .o_rb_rdata(rb_rdata), .o_pb_rdata(pb_rdata),
    .o_dma_rdata(dma_rdata), .o_wr_stb(wr_stb), .o_wr_region(wr_region),
    .o_dma_wr_stb(dma_wr_stb), .o_dma_wr_region(dma_wr_region),
    .o_ext_cs(ext_cs), .o_ext_rd(ext_rd), .o_ext_wr(ext_wr), .o_ext_addr(ext_addr)
  );

  bus_requester_model partner (
    .i_clk(clk), .i_nrst(nrst), .i_go(go), .i_done(done), .o_req(req), .o_lat(lat)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Launches the masked sources together and waits, bounded, for all to finish
  task automatic run(input logic [3:0] m);
    int n;
    go <= m;
    @(posedge clk);
    go <= 4'h0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (req !== 4'h0 && n < 80);
    if (n >= 80) chk("requests finished", 32'h0, 32'(req));
  endtask

  task automatic one(input logic [3:0] m, input int s, input logic [7:0] exp);
    run(m);
    chk("latency", 32'(exp), 32'(lat[s]));
  endtask

  task automatic dma_denied(input logic [31:0] a);
    dma_addr <= a;
    one(4'b1000, 3, 8'd2);
    chk("dma error", 32'h1, 32'(err_seen));
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_low_ram();
    rb_addr <= 32'h0000_BFFF;
    one(4'b0010, 1, 8'd2);
    chk("low ram data", 32'hD000_0000, rb_rdata);
    dma_denied(32'h0000_8000);
  endtask

  task automatic t_high_ram();
    rb_addr <= 32'h0000_C000;
    one(4'b0010, 1, 8'd2);
    pb_addr <= 22'h00_FFFF;
    one(4'b0100, 2, 8'd3);
    wb_addr <= 32'h0000_C200;
    wb_prog <= 1'b1;
    one(4'b0001, 0, 8'd3);
    chk("write region", 32'h1, 32'(wr_rg_seen));
    wb_prog <= 1'b0;
    one(4'b0001, 0, 8'd2);
    dma_addr <= 32'h0000_C000;
    one(4'b1000, 3, 8'd5);
    chk("dma data", 32'hD000_0001, dma_rdata);
    chk("dma error", 32'h0, 32'(err_seen));
  endtask

  task automatic t_otp_flash();
    rb_addr <= 32'h0038_0400;
    otp_wait <= 4'h0;
    one(4'b0010, 1, 8'd3);
    otp_wait <= 4'h3;
    one(4'b0010, 1, 8'd5);
    dma_denied(32'h0038_0400);
    rb_addr <= 32'h0030_0000;
    pg_wait <= 4'h0;
    rn_wait <= 4'h0;
    one(4'b0010, 1, 8'd3);
    pg_wait <= 4'h2;
    rn_wait <= 4'h1;
    paged <= 1'b0;
    one(4'b0010, 1, 8'd4);
    pg_wait <= 4'h1;
    rn_wait <= 4'h5;
    one(4'b0010, 1, 8'd7);
    paged <= 1'b1;
    one(4'b0010, 1, 8'd3);
    dma_denied(32'h0030_0000);
    rb_addr <= 32'h0033_FFF8;
    one(4'b0010, 1, 8'd18);
    dma_denied(32'h0033_FFFF);
    pb_addr <= 22'h3F_E000;
    one(4'b0100, 2, 8'd3);
    chk("boot rom data", 32'hD000_0006, pb_rdata);
    dma_denied(32'h003F_E000);
  endtask

  task automatic t_ext();
    ext_wait <= 4'h2;
    rb_addr <= 32'h0010_0000;
    one(4'b0010, 1, 8'd4);
    chk("port strobe", 32'h1, 32'(ext_seen));
    dma_addr <= 32'h0010_0004;
    dma_we <= 1'b1;
    one(4'b1000, 3, 8'd7);
    chk("port write", 32'h2, 32'(ext_seen));
    chk("port address", 32'h4, 32'(ext_a_seen));
    chk("dma write region", 32'h2, 32'(dwr_rg_seen));
    ext_wait <= 4'h0;
    one(4'b0010, 1, 8'd3);
    rdy_en <= 1'b1;
    rdy <= 1'b0;
    fork
      run(4'b0010);
      begin
        repeat (9) @(posedge clk);
        rdy <= 1'b1;
      end
    join
    chk("ready stretch", 32'hA, 32'(lat[1]));
    rdy_en <= 1'b0;
    wb_addr <= 32'h0010_0010;
    wbuf_en <= 1'b1;
    one(4'b0001, 0, 8'd3);
    wbuf_room <= 1'b1;
    one(4'b0001, 0, 8'd2);
    wbuf_en <= 1'b0;
    dma_we <= 1'b0;
    // Posted write keeps the port busy; let its waveform finish
    repeat (12) @(posedge clk);
    ext_wait <= 4'h1;
    one(4'b1010, 1, 8'd4);
  endtask

  task automatic t_priority();
    wb_addr <= 32'h0000_8000;
    rb_addr <= 32'h0000_8001;
    pb_addr <= 22'h00_8002;
    run(4'b0111);
    chk("write first", 32'h2, 32'(lat[0]));
    chk("read after write", 32'h1, 32'(lat[1] > lat[0]));
    chk("fetch last", 32'h1, 32'(lat[2] > lat[1]));
    chk("stalled read data", 32'hD000_0000, rb_rdata);
    rb_addr <= 32'h0000_C004;
    dma_addr <= 32'h0000_C008;
    run(4'b1010);
    chk("cpu beats dma", 32'h2, 32'(lat[1]));
    chk("dma after cpu", 32'h1, 32'(lat[3] > 8'd5));
    rb_addr <= 32'h0040_8000;
    pb_addr <= 22'h00_C000;
    run(4'b0111);
    chk("parallel write", 32'h2, 32'(lat[0]));
    chk("parallel read", 32'h2, 32'(lat[1]));
    chk("parallel fetch", 32'h3, 32'(lat[2]));
    chk("upper address bits", 32'hD000_0007, rb_rdata);
  endtask

  // ****************************************************************
  // Sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_low_ram();
    t_high_ram();
    t_otp_flash();
    t_ext();
    t_priority();
    wrap_up();
  end

  initial begin
    repeat (6000) @(posedge clk);
    errors++;
    $display("mismatch watchdog expected finish seen timeout");
    wrap_up();
  end
endmodule
`default_nettype wire
